// *** design/cksyn_pkg.sv ***
// cksyn_pkg: constants and types for the global configuration bank
// assumes one 125 MHz clock, an APB slave and byte-wide registers
//
// Overview of operation
// - bank bit maps memory from index one up
// - rom window beats memory bank select
// - soft reset clears all but reset bits
// - no pin capture or boot in soft reset
// - hard reset acts as external reset
// - global stop stops outputs sourced 0001
// - ring oscillator powered down when set
// - open-drain bit: data out drives low only
// - crystal pin mode field selects pin use
// - pll enable bit drives analog pll
// - input enable bits power input clocks
// - output enable bits power each output
// - group mux field selects clock path
// - mux fields steer groups A to F
// - individual stop ORed, gated by source
package cksyn_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_BANK = 10'h000;
    localparam logic [9:0] IDX_CFG1 = 10'h001;
    localparam logic [9:0] IDX_CFG2 = 10'h002;
    localparam logic [9:0] IDX_PLL = 10'h003;
    localparam logic [9:0] IDX_INEN = 10'h004;
    localparam logic [9:0] IDX_OUTEN1 = 10'h005;
    localparam logic [9:0] IDX_OUTEN2 = 10'h006;
    localparam logic [9:0] IDX_MUX1 = 10'h007;
    localparam logic [9:0] IDX_MUX2 = 10'h008;

    // writable bit masks
    localparam logic [7:0] MASK_BANK = 8'h80;
    localparam logic [7:0] MASK_CFG1 = 8'hEE;
    localparam logic [7:0] MASK_CFG2 = 8'hF7;
    localparam logic [7:0] MASK_PLL = 8'h01;
    localparam logic [7:0] MASK_INEN = 8'h07;
    localparam logic [7:0] MASK_OUTEN1 = 8'hFF;
    localparam logic [7:0] MASK_OUTEN2 = 8'h03;
    localparam logic [7:0] MASK_MUX = 8'h3F;
    localparam logic [7:0] RST_VAL = 8'h00;

    // bits kept through each kind of reset
    localparam logic [7:0] KEEP_HARD = 8'h40;
    localparam logic [7:0] KEEP_SOFT = 8'hC0;

    // field positions
    localparam int BIT_BANK = 7;
    localparam int BIT_SOFT = 7;
    localparam int BIT_HARD = 6;
    localparam int BIT_STOP = 5;
    localparam int BIT_RING = 3;
    localparam int BIT_ODO = 1;
    localparam int BIT_DOUBLE = 2;

    // field encodings
    localparam logic [1:0] XM_XTAL = 2'h1;
    localparam logic [1:0] XM_SE = 2'h2;
    localparam logic [1:0] MUX_INT = 2'h0;
    localparam logic [1:0] MUX_FRAC = 2'h1;
    localparam logic [1:0] MUX_P2 = 2'h3;
    localparam logic [3:0] SRC_REG = 4'h1;

    localparam int NUM_OUT = 10;
    localparam int NUM_IN = 3;
    localparam int NUM_GRP = 6;

    typedef enum logic [2:0] {
        ST_START = 3'b001,
        ST_RUN = 3'b010,
        ST_HOLD = 3'b100
    } cksyn_state_t;

    typedef struct packed {
        logic [7:0] bank;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] pll;
        logic [7:0] inen;
        logic [7:0] outen1;
        logic [7:0] outen2;
        logic [7:0] mux1;
        logic [7:0] mux2;
        logic [31:0] rdata;
        logic mem_we;
        logic [9:0] mem_waddr;
        logic [7:0] mem_wdata;
        logic cap;
        logic boot;
        cksyn_state_t st;
    } cksyn_regs_t;

    typedef struct packed {
        logic stop;
    } cksyn_stop_t;

endpackage : cksyn_pkg

// *** design/cksyn_stop.sv ***
// cksyn_stop: internal stop signal of one output clock
// assumes source field and individual bit come from the same clock
`timescale 1ns/100ps
module cksyn_stop (
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic [3:0] src, // stop source field
    input wire logic ind, // individual stop bit
    input wire logic glb, // global stop bit
    output logic stop // internal stop, registered
);

    cksyn_pkg::cksyn_stop_t q;
    cksyn_pkg::cksyn_stop_t n;

    always_comb begin
        n = q;
        // only the register source lets either bit stop the clock
        n.stop = (src == cksyn_pkg::SRC_REG) && (ind || glb);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign stop = q.stop;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_stop_global: assert property (
        src == cksyn_pkg::SRC_REG && glb |=> stop)
        else $error("global stop did not stop output");
    chk_stop_source: assert property (
        src != cksyn_pkg::SRC_REG |=> !stop)
        else $error("stop taken without register source");

endmodule : cksyn_stop

// *** design/cksyn_regs.sv ***
// cksyn_regs: global configuration register bank on an APB slave
// assumes memory windows answer reads combinationally on MEM_RDATA
`timescale 1ns/100ps
module cksyn_regs (
    input wire logic CLK, // 125 MHz system clock
    input wire logic RESETN, // external reset pin, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb enable
    input wire logic PWRITE, // apb direction
    input wire logic [11:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    input wire logic [3:0] PSTRB, // apb byte strobes
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error
    input wire logic ROM_SEL, // rom window select
    output logic ROM_WIN, // rom mapped from index one
    output logic EE_WIN, // memory mapped from index one
    output logic [9:0] MEM_RADDR, // window read index
    input wire logic [7:0] MEM_RDATA, // window read data
    output logic MEM_WE, // window write pulse
    output logic [9:0] MEM_WADDR, // window write index
    output logic [7:0] MEM_WDATA, // window write data
    output logic DEV_RST_N, // device logic reset, active low
    output logic CAPTURE_PINS, // latch pin defaults pulse
    output logic BOOT_START, // start boot controller pulse
    input wire logic [39:0] STOP_SRC, // stop source fields
    input wire logic [9:0] STOP_IND, // individual stop bits
    output logic [9:0] OUT_STOP, // internal stop per output
    output logic RING_OSC_PD, // ring oscillator power down
    input wire logic SDO_DATA, // serial data out value
    input wire logic SDO_DRIVE, // serial interface drives pin
    output logic SDO_O, // data out pin value
    output logic SDO_OE, // data out pin enable
    output logic DOUBLER_EN, // clock doubler enable
    output logic XTAL_DRV_EN, // crystal driver on both pins
    output logic XTAL_A_SE_IN, // first pin single-ended input
    output logic PLL_EN, // analog pll enable
    output logic [2:0] IC_EN, // input clock enables
    output logic [9:0] OC_EN, // output clock enables
    output logic [5:0] GRP_INT, // group uses integer divider
    output logic [5:0] GRP_FRAC, // group uses frac or bypass
    output logic [5:0] GRP_PATH2 // group uses second path
);

    cksyn_pkg::cksyn_regs_t q;
    cksyn_pkg::cksyn_regs_t n;

    logic [9:0] idx;
    logic setup;
    logic access;
    logic win;
    logic unmapped;
    logic wr_reg;
    logic wr_mem;
    logic [7:0] rd_byte;
    logic [7:0] wb;
    logic [11:0] mux_all;

    ////////////////////////////////////////////////////////////////////
    // bus decode

    assign idx = PADDR[11:2];
    assign setup = PSEL && !PENABLE;
    assign access = PSEL && PENABLE;
    // rom select wins; index zero always stays the bank register
    assign ROM_WIN = ROM_SEL;
    assign EE_WIN = q.bank[cksyn_pkg::BIT_BANK] && !ROM_SEL;
    assign win = (ROM_WIN || EE_WIN) && (idx != cksyn_pkg::IDX_BANK);
    assign unmapped = !win && (idx > cksyn_pkg::IDX_MUX2);
    assign wr_reg = access && PWRITE && PSTRB[0] && !win && !unmapped;
    assign wr_mem = access && PWRITE && PSTRB[0] && win;
    assign wb = PWDATA[7:0];
    assign MEM_RADDR = idx;

    // zero wait state; read data was taken in the setup cycle
    assign PREADY = 1'b1;
    assign PSLVERR = access && unmapped;
    assign PRDATA = q.rdata;

    always_comb begin
        rd_byte = 8'h00;
        if (win) begin
            rd_byte = MEM_RDATA;
        end else begin
            case (idx)
                cksyn_pkg::IDX_BANK: rd_byte = q.bank;
                cksyn_pkg::IDX_CFG1: rd_byte = q.cfg1;
                cksyn_pkg::IDX_CFG2: rd_byte = q.cfg2;
                cksyn_pkg::IDX_PLL: rd_byte = q.pll;
                cksyn_pkg::IDX_INEN: rd_byte = q.inen;
                cksyn_pkg::IDX_OUTEN1: rd_byte = q.outen1;
                cksyn_pkg::IDX_OUTEN2: rd_byte = q.outen2;
                cksyn_pkg::IDX_MUX1: rd_byte = q.mux1;
                cksyn_pkg::IDX_MUX2: rd_byte = q.mux2;
                default: rd_byte = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        n = q;
        n.mem_we = 1'b0;
        n.cap = 1'b0;
        n.boot = 1'b0;
        if (setup) begin
            n.rdata = {24'h000000, rd_byte};
        end
        // masks keep reserved bits at zero
        if (wr_reg) begin
            case (idx)
                cksyn_pkg::IDX_BANK:
                    n.bank = wb & cksyn_pkg::MASK_BANK;
                cksyn_pkg::IDX_CFG1:
                    n.cfg1 = wb & cksyn_pkg::MASK_CFG1;
                cksyn_pkg::IDX_CFG2:
                    n.cfg2 = wb & cksyn_pkg::MASK_CFG2;
                cksyn_pkg::IDX_PLL:
                    n.pll = wb & cksyn_pkg::MASK_PLL;
                cksyn_pkg::IDX_INEN:
                    n.inen = wb & cksyn_pkg::MASK_INEN;
                cksyn_pkg::IDX_OUTEN1:
                    n.outen1 = wb & cksyn_pkg::MASK_OUTEN1;
                cksyn_pkg::IDX_OUTEN2:
                    n.outen2 = wb & cksyn_pkg::MASK_OUTEN2;
                cksyn_pkg::IDX_MUX1:
                    n.mux1 = wb & cksyn_pkg::MASK_MUX;
                cksyn_pkg::IDX_MUX2:
                    n.mux2 = wb & cksyn_pkg::MASK_MUX;
                default: n.bank = q.bank;
            endcase
        end
        if (wr_mem) begin
            n.mem_we = 1'b1;
            n.mem_waddr = idx;
            n.mem_wdata = wb;
        end
        // hard reset keeps only itself; soft keeps both reset bits
        if (n.cfg1[cksyn_pkg::BIT_HARD]) begin
            n.bank = cksyn_pkg::RST_VAL;
            n.cfg1 = n.cfg1 & cksyn_pkg::KEEP_HARD;
            n.cfg2 = cksyn_pkg::RST_VAL;
            n.pll = cksyn_pkg::RST_VAL;
            n.inen = cksyn_pkg::RST_VAL;
            n.outen1 = cksyn_pkg::RST_VAL;
            n.outen2 = cksyn_pkg::RST_VAL;
            n.mux1 = cksyn_pkg::RST_VAL;
            n.mux2 = cksyn_pkg::RST_VAL;
        end else if (n.cfg1[cksyn_pkg::BIT_SOFT]) begin
            n.bank = cksyn_pkg::RST_VAL;
            n.cfg1 = n.cfg1 & cksyn_pkg::KEEP_SOFT;
            n.cfg2 = cksyn_pkg::RST_VAL;
            n.pll = cksyn_pkg::RST_VAL;
            n.inen = cksyn_pkg::RST_VAL;
            n.outen1 = cksyn_pkg::RST_VAL;
            n.outen2 = cksyn_pkg::RST_VAL;
            n.mux1 = cksyn_pkg::RST_VAL;
            n.mux2 = cksyn_pkg::RST_VAL;
        end
        // startup after the pin reset or after a hard reset ends
        case (q.st)
            cksyn_pkg::ST_START: begin
                n.st = cksyn_pkg::ST_RUN;
                // soft reset suppresses both capture and boot
                if (!n.cfg1[cksyn_pkg::BIT_SOFT]) begin
                    n.cap = 1'b1;
                    n.boot = 1'b1;
                end
            end
            cksyn_pkg::ST_RUN: begin
                if (q.cfg1[cksyn_pkg::BIT_HARD]) begin
                    n.st = cksyn_pkg::ST_HOLD;
                end
            end
            cksyn_pkg::ST_HOLD: begin
                if (!q.cfg1[cksyn_pkg::BIT_HARD]) begin
                    n.st = cksyn_pkg::ST_START;
                end
            end
            default: n.st = cksyn_pkg::ST_START;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            q <= '0;
            q.st <= cksyn_pkg::ST_START;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign MEM_WE = q.mem_we;
    assign MEM_WADDR = q.mem_waddr;
    assign MEM_WDATA = q.mem_wdata;
    assign CAPTURE_PINS = q.cap;
    assign BOOT_START = q.boot;
    assign DEV_RST_N = !(q.cfg1[cksyn_pkg::BIT_SOFT] ||
                         q.cfg1[cksyn_pkg::BIT_HARD]);

    assign RING_OSC_PD = q.cfg1[cksyn_pkg::BIT_RING];
    // open drain never drives high, so a pull-up is needed
    assign SDO_O = q.cfg1[cksyn_pkg::BIT_ODO] ? 1'b0 : SDO_DATA;
    assign SDO_OE = q.cfg1[cksyn_pkg::BIT_ODO] ?
                    (SDO_DRIVE && !SDO_DATA) : SDO_DRIVE;

    assign DOUBLER_EN = q.cfg2[cksyn_pkg::BIT_DOUBLE];
    assign XTAL_DRV_EN = (q.cfg2[1:0] == cksyn_pkg::XM_XTAL);
    assign XTAL_A_SE_IN = (q.cfg2[1:0] == cksyn_pkg::XM_SE);
    assign PLL_EN = q.pll[0];
    assign IC_EN = q.inen[cksyn_pkg::NUM_IN-1:0];
    assign OC_EN = {q.outen2[1:0], q.outen1};

    // groups A..C from the first mux register, D..F from the second
    assign mux_all = {q.mux2[5:0], q.mux1[5:0]};

    genvar g;
    generate
        for (g = 0; g < cksyn_pkg::NUM_GRP; g = g + 1) begin : gen_grp
            // unused code 10 selects no path at all
            assign GRP_INT[g] = (mux_all[2*g+1:2*g] ==
                                 cksyn_pkg::MUX_INT);
            assign GRP_FRAC[g] = (mux_all[2*g+1:2*g] ==
                                  cksyn_pkg::MUX_FRAC);
            assign GRP_PATH2[g] = (mux_all[2*g+1:2*g] ==
                                   cksyn_pkg::MUX_P2);
        end
        for (g = 0; g < cksyn_pkg::NUM_OUT; g = g + 1) begin : gen_stop
            cksyn_stop u_stop (
                .clk(CLK),
                .resetn(RESETN),
                .src(STOP_SRC[4*g+3:4*g]),
                .ind(STOP_IND[g]),
                .glb(q.cfg1[cksyn_pkg::BIT_STOP]),
                .stop(OUT_STOP[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    chk_bank_window_on: assert property (
        $rose(q.bank[7]) && !ROM_SEL |-> EE_WIN)
        else $error("bank bit did not map memory");
    chk_rom_window_wins: assert property (
        ROM_SEL |-> ROM_WIN && !EE_WIN)
        else $error("memory window beat rom window");
    chk_soft_clears: assert property (
        q.cfg1[7] |-> q.pll == 8'h00 && q.outen1 == 8'h00 && !DEV_RST_N)
        else $error("soft reset left device state");
    chk_soft_no_boot: assert property (
        q.cfg1[7] |-> !CAPTURE_PINS && !BOOT_START)
        else $error("boot started during soft reset");
    chk_hard_boot_seq: assert property (
        $fell(q.cfg1[6]) |-> ##2 ((BOOT_START && CAPTURE_PINS) || q.cfg1[7]))
        else $error("no boot after hard reset");
    chk_hard_clears: assert property (
        q.cfg1[6] |-> !q.cfg1[7] && q.inen == 8'h00 && q.bank == 8'h00)
        else $error("hard reset left state");
    chk_ring_osc_write: assert property (
        wr_reg && idx == cksyn_pkg::IDX_CFG1 && !PWDATA[7] && !PWDATA[6]
        |=> RING_OSC_PD == $past(PWDATA[3]))
        else $error("ring oscillator bit not applied");
    chk_open_drain_pin: assert property (
        q.cfg1[1] |-> !SDO_O && SDO_OE == (SDO_DRIVE && !SDO_DATA))
        else $error("open drain pin drove high");
    chk_xtal_unused: assert property (
        q.cfg2[1:0] == 2'h3 || q.cfg2[1:0] == 2'h0
        |-> !XTAL_DRV_EN && !XTAL_A_SE_IN)
        else $error("crystal pins on in off mode");
    chk_pll_write: assert property (
        wr_reg && idx == cksyn_pkg::IDX_PLL && !q.cfg1[7] && !q.cfg1[6]
        |=> PLL_EN == $past(PWDATA[0]))
        else $error("pll enable not applied");
    chk_input_write: assert property (
        wr_reg && idx == cksyn_pkg::IDX_INEN && !q.cfg1[7] && !q.cfg1[6]
        |=> IC_EN == $past(PWDATA[2:0]))
        else $error("input enables not applied");
    chk_output_order: assert property (
        OC_EN[9:8] == q.outen2[1:0] && OC_EN[0] == q.outen1[0])
        else $error("output enable order wrong");
    chk_mux_exclusive: assert property (
        (GRP_INT & GRP_FRAC) == 6'h00 && (GRP_FRAC & GRP_PATH2) == 6'h00)
        else $error("two paths on one group");
    chk_group_steer: assert property (
        GRP_PATH2[2] == (q.mux1[5:4] == 2'h3) &&
        GRP_INT[0] == (q.mux1[1:0] == 2'h0))
        else $error("mux field steers wrong group");
    chk_reserved_zero: assert property (
        setup && idx == cksyn_pkg::IDX_PLL && !win |=> PRDATA[31:1] == 0)
        else $error("reserved bits read nonzero");

    cov_boot: cover property (BOOT_START);
    cov_mem_write: cover property (wr_mem && EE_WIN);
    cov_bus_error: cover property (PSLVERR);
    cov_hard_end: cover property ($fell(q.cfg1[6]));

endmodule : cksyn_regs

// *** verif/cksyn_regs_tb_top.sv ***
// cksyn_regs_tb_top: self-checking bench for the configuration bank
// assumes zero-wait apb slave and one 125 MHz clock
`timescale 1ns/100ps
module cksyn_regs_tb_top;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic [3:0] PSTRB = 4'hF;
    logic PREADY, PSLVERR, ROM_WIN, EE_WIN, MEM_WE, DEV_RST_N;
    logic ROM_SEL = 1'b0, SDO_DATA = 1'b0, SDO_DRIVE = 1'b0;
    logic [7:0] MEM_RDATA = 8'h00, MEM_WDATA;
    logic [9:0] MEM_RADDR, MEM_WADDR, OUT_STOP, OC_EN;
    logic [9:0] STOP_IND = 10'h000;
    logic [39:0] STOP_SRC = 40'h0;
    logic CAPTURE_PINS, BOOT_START, RING_OSC_PD, SDO_O, SDO_OE;
    logic DOUBLER_EN, XTAL_DRV_EN, XTAL_A_SE_IN, PLL_EN;
    logic [2:0] IC_EN;
    logic [5:0] GRP_INT, GRP_FRAC, GRP_PATH2;
    int err_total = 0;
    int checks_done = 0;
    int pulses = 0;
    integer seed;
    logic win = 1'b0;
    logic [7:0] sh [0:8];

    cksyn_regs u_cksyn_regs (
        .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .ROM_SEL(ROM_SEL), .ROM_WIN(ROM_WIN), .EE_WIN(EE_WIN),
        .MEM_RADDR(MEM_RADDR), .MEM_RDATA(MEM_RDATA), .MEM_WE(MEM_WE),
        .MEM_WADDR(MEM_WADDR), .MEM_WDATA(MEM_WDATA),
        .DEV_RST_N(DEV_RST_N), .CAPTURE_PINS(CAPTURE_PINS),
        .BOOT_START(BOOT_START), .STOP_SRC(STOP_SRC), .STOP_IND(STOP_IND),
        .OUT_STOP(OUT_STOP), .RING_OSC_PD(RING_OSC_PD),
        .SDO_DATA(SDO_DATA), .SDO_DRIVE(SDO_DRIVE), .SDO_O(SDO_O),
        .SDO_OE(SDO_OE), .DOUBLER_EN(DOUBLER_EN),
        .XTAL_DRV_EN(XTAL_DRV_EN), .XTAL_A_SE_IN(XTAL_A_SE_IN),
        .PLL_EN(PLL_EN), .IC_EN(IC_EN), .OC_EN(OC_EN), .GRP_INT(GRP_INT),
        .GRP_FRAC(GRP_FRAC), .GRP_PATH2(GRP_PATH2)
    );

    always #4 CLK = ~CLK;

    // one count per cycle in which both boot pulses stand together
    always @(posedge CLK) begin
        if (CAPTURE_PINS === 1'b1 && BOOT_START === 1'b1) begin
            pulses <= pulses + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [39:0] exp,
                       input logic [39:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    function automatic logic [7:0] wmask(input int i);
        case (i)
            0: wmask = cksyn_pkg::MASK_BANK;
            1: wmask = cksyn_pkg::MASK_CFG1;
            2: wmask = cksyn_pkg::MASK_CFG2;
            3: wmask = cksyn_pkg::MASK_PLL;
            4: wmask = cksyn_pkg::MASK_INEN;
            5: wmask = cksyn_pkg::MASK_OUTEN1;
            6: wmask = cksyn_pkg::MASK_OUTEN2;
            default: wmask = cksyn_pkg::MASK_MUX;
        endcase
    endfunction : wmask

    // returns {path2, frac, int} for groups A..F
    function automatic logic [17:0] grp_exp(input logic [11:0] f);
        logic [1:0] c;
        grp_exp = 18'h0;
        for (int g = 0; g < 6; g++) begin
            c = f[2*g +: 2];
            grp_exp[g] = (c == 2'h0);
            grp_exp[6 + g] = (c == 2'h1);
            grp_exp[12 + g] = (c == 2'h3);
        end
    endfunction : grp_exp

    // upper data bits are random: they must not reach any register
    task automatic xfer(input logic w, input logic [9:0] i,
                        input logic [7:0] d, input logic [3:0] st,
                        output logic [31:0] rd, output logic er);
        int n;
        logic [31:0] rn;
        rn = $random(seed);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= {i, 2'b00};
        PWDATA <= {rn[31:8], d};
        PSTRB <= st;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_total++;
            end_sim();
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, i, d, 4'hF, r, e);
        chk("wr_err", {39'h0, i > 10'd8 && !win}, {39'h0, e});
    endtask : wr

    task automatic rd(input logic [9:0] i, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        xfer(1'b0, i, 8'h00, 4'h0, r, e);
        chk("rd_data", {32'h0, x}, {8'h0, r});
        chk("rd_err", {39'h0, i > 10'd8 && !win}, {39'h0, e});
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] v, r;
        logic e;
        logic [39:0] src;
        logic [9:0] ind;
        int p;
        seed = 32'hC4BA;
        repeat (12) @(posedge CLK);
        RESETN <= 1'b1;
        repeat (4) @(posedge CLK);
        chk("boot", 1, pulses);
        for (int i = 0; i < 9; i++) begin
            sh[i] = 8'h00;
            rd(10'(i), 8'h00);
        end
        wr(10'd5, 8'hFF);
        wr(10'd6, 8'h03);
        for (int k = 0; k < 4; k++) begin
            for (int i = 1; i < 9; i++) begin
                v = $random(seed);
                if (i == 1) v[7:6] = 2'b00;
                if (i == 2) v[7:4] = 4'h0;
                if (i == 2) v[1:0] = 2'(k);
                if (i >= 7) v[5:0] = {3{2'(k)}};
                sh[i] = v[7:0] & wmask(i);
                wr(10'(i), v[7:0]);
                rd(10'(i), sh[i]);
            end
            @(negedge CLK);
            chk("ring_pd", sh[1][3], RING_OSC_PD);
            chk("dbl", sh[2][2], DOUBLER_EN);
            chk("xtal", sh[2][1:0] == 2'h1, XTAL_DRV_EN);
            chk("xtal_a_se", sh[2][1:0] == 2'h2, XTAL_A_SE_IN);
            chk("pll", sh[3][0], PLL_EN);
            chk("ic_en", sh[4][2:0], IC_EN);
            chk("oc_en", {sh[6][1:0], sh[5]}, OC_EN);
            chk("grp", grp_exp({sh[8][5:0], sh[7][5:0]}),
                {GRP_PATH2, GRP_FRAC, GRP_INT});
        end
        xfer(1'b1, 10'd3, ~sh[3], 4'hE, r, e);
        rd(10'd3, sh[3]);
        for (int k = 0; k < 4; k++) begin
            v = $random(seed);
            wr(k == 0 ? 10'd9 : 10'(9 + (v & 32'h3F0)), v[7:0]);
            rd(k == 0 ? 10'h3FF : 10'(9 + (v & 32'h3F0)), 8'h00);
        end
        for (int t = 0; t < 12; t++) begin
            sh[1] = {2'b00, t[0], sh[1][4:2], t[1], 1'b0};
            wr(10'd1, sh[1]);
            for (int k = 0; k < 10; k++) begin
                v = $random(seed);
                src[4*k +: 4] = v[4] ? 4'h1 : v[3:0];
            end
            v = $random(seed);
            ind = v[9:0];
            STOP_SRC <= src;
            STOP_IND <= ind;
            SDO_DATA <= v[10];
            SDO_DRIVE <= v[11];
            @(posedge CLK);
            @(negedge CLK);
            for (int k = 0; k < 10; k++) begin
                chk("stop", src[4*k +: 4] == 4'h1 && (ind[k] || t[0]),
                    OUT_STOP[k]);
            end
            chk("sdo_o", t[1] ? 1'b0 : v[10], SDO_O);
            chk("sdo_oe", v[11] && !(t[1] && v[10]), SDO_OE);
        end
        v = $random(seed);
        wr(10'd0, v[7:0] | 8'h80);
        win = 1'b1;
        MEM_RDATA <= v[15:8];
        @(negedge CLK);
        chk("ee_win", 2'b01, {ROM_WIN, EE_WIN});
        rd(10'd5, v[15:8]);
        wr(10'd9, v[23:16]);
        @(negedge CLK);
        chk("mem_we", {1'b1, 10'd9, v[23:16], 10'd9},
            {MEM_WE, MEM_WADDR, MEM_WDATA, MEM_RADDR});
        @(negedge CLK);
        chk("mem_we_end", 1'b0, MEM_WE);
        rd(10'd0, 8'h80);
        ROM_SEL <= 1'b1;
        @(negedge CLK);
        chk("rom_win", 2'b10, {ROM_WIN, EE_WIN});
        wr(10'd0, 8'h00);
        rd(10'd3, v[15:8]);
        ROM_SEL <= 1'b0;
        win = 1'b0;
        rd(10'd3, sh[3]);
        wr(10'd1, 8'h80);
        @(negedge CLK);
        chk("soft_rst", 1'b0, DEV_RST_N);
        rd(10'd3, 8'h00);
        wr(10'd3, 8'h01);
        rd(10'd3, 8'h00);
        rd(10'd1, 8'h80);
        p = pulses;
        wr(10'd1, 8'h00);
        repeat (8) @(posedge CLK);
        chk("soft_boot", p, pulses);
        chk("rst_end", 1'b1, DEV_RST_N);
        wr(10'd3, 8'h01);
        wr(10'd1, 8'h40);
        rd(10'd3, 8'h00);
        rd(10'd1, 8'h40);
        chk("hard_rst", 1'b0, DEV_RST_N);
        p = pulses;
        wr(10'd1, 8'h00);
        repeat (8) @(posedge CLK);
        chk("hard_boot", p + 1, pulses);
        end_sim();
    end
endmodule : cksyn_regs_tb_top
